// file: bench/smps_dbg_host.sv
`timescale 1ns/1ps
`default_nettype none
module smps_dbg_host (
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic send_in,
    input wire logic [2:0] code_in,
    output logic dbg_cmd_valid_out,
    output logic [2:0] dbg_cmd_out
);
    // one-cycle command strobe; the code lines toggle while idle so a stale code is never mistaken for a new one
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            dbg_cmd_valid_out <= 1'b0;
            dbg_cmd_out <= 3'h0;
        end else if (send_in) begin
            dbg_cmd_valid_out <= 1'b1;
            dbg_cmd_out <= code_in;
        end else begin
            dbg_cmd_valid_out <= 1'b0;
            dbg_cmd_out <= ~dbg_cmd_out;
        end
    end
endmodule
`default_nettype wire

// file: bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk_sys_in = 1'b0;
    logic rst_in = 1'b1;
    logic [3:0] addr_in = 4'h0;
    logic [7:0] wdata_in = 8'h00;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic [3:0] ev = 4'h0;
    logic send = 1'b0;
    logic [2:0] code = 3'h0;
    logic dv, ack, err, rej, mgo, ill, srst, cpu, per, dclk, regf, cgen, osc, asb, kpd, lat;
    logic [2:0] dc;
    logic [1:0] mode;
    logic [7:0] rdata_out;
    logic rd_seen = 1'b0;
    logic [7:0] exp_q[$];
    logic [7:0] c;
    int errors = 0;
    int tests_run = 0;
    int cyc = 0;

    // system clock, 10 ns period
    always #5 clk_sys_in = ~clk_sys_in;

    smps_dbg_host u_smps_dbg_host (.clk_sys_in, .rst_in, .send_in(send), .code_in(code),
        .dbg_cmd_valid_out(dv), .dbg_cmd_out(dc));

    smps_top u_smps_top (.clk_sys_in, .rst_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
        .stop_instr_in(ev[0]), .wake_irq_in(ev[1]), .keypad_wake_in(ev[2]), .stop2_wake_in(ev[3]),
        .dbg_cmd_valid_in(dv), .dbg_cmd_in(dc), .dbg_ack_out(ack), .dbg_err_out(err),
        .dbg_rej_out(rej), .dbg_mem_go_out(mgo), .illegal_reset_out(ill), .sys_reset_out(srst),
        .stop_mode_out(mode), .cpu_clk_en_out(cpu), .periph_clk_en_out(per), .debug_clk_en_out(dclk),
        .regulator_full_out(regf), .clkgen_active_out(cgen), .osc_run_out(osc), .adc_standby_out(asb),
        .keypad_enable_out(kpd), .pin_latch_out(lat));

    // compare one value and count it
    task automatic chk(input string n, input logic [9:0] s, input logic [9:0] e);
        tests_run++;
        if (s !== e) begin
            errors++;
            $display("FAIL %s expected %h seen %h", n, e, s);
        end
    endtask

    // final counts and verdict
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // expected levels {mode, cpu, periph, debug, regulator, clock generator, adc standby, keypad, latch}
    function automatic logic [9:0] expv(logic [1:0] m, logic [7:0] cr, logic d, logic l);
        if (m == smps_pkg::MODE_STOP2) return {m, 7'h02, l};
        if (m == smps_pkg::MODE_STOP3) return {m, 2'h0, d, d | (cr[2] & cr[3]), d, ~cr[5], 1'h1, l};
        return {m, 7'h7D, l};
    endfunction

    task automatic lv(input logic [1:0] m, input logic [7:0] cr, input logic d, input logic l);
        #1;
        chk("levels", {mode, cpu, per, dclk, regf, cgen, asb, kpd, lat}, expv(m, cr, d, l));
    endtask

    // register bus write and read; a read notes its expected data
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge clk_sys_in);
        wr_in <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge clk_sys_in);
        addr_in <= a;
        rd_in <= 1'b1;
        exp_q.push_back(e);
        @(posedge clk_sys_in);
        rd_in <= 1'b0;
    endtask

    // one-cycle event: 0 stop, 1 wake interrupt, 2 keypad wake, 3 stop2 wake
    task automatic pulse(input int i);
        @(posedge clk_sys_in);
        ev[i] <= 1'b1;
        @(posedge clk_sys_in);
        ev <= 4'h0;
        #1;
    endtask

    // debug command through the host model; returns once the answer pulses stand
    task automatic dbg(input logic [2:0] k);
        @(posedge clk_sys_in);
        send <= 1'b1;
        code <= k;
        @(posedge clk_sys_in);
        send <= 1'b0;
        @(posedge clk_sys_in);
        #1;
    endtask

    // read data monitor: takes the oldest note in the cycle after each read
    always @(posedge clk_sys_in) begin
        rd_seen <= rd_in;
        if (rd_seen) begin
            if (exp_q.size() == 0) chk("read queue", 10'h1, 10'h0);
            else chk("rdata", rdata_out, exp_q.pop_front());
        end
    end

    // run-length guard
    always @(posedge clk_sys_in) begin
        cyc <= cyc + 1;
        if (cyc > 20000) begin
            errors++;
            close_out();
        end
    end

    initial begin
        void'($urandom(24822));
        repeat (5) @(posedge clk_sys_in);
        rst_in <= 1'b0;
        // reset values, read-only status, unmapped address, stop while disabled
        rd(4'h0, 8'h00);
        rd(4'h1, 8'h00);
        wr(4'h2, 8'hFF);
        rd(4'h2, 8'h00);
        rd(4'hF, 8'h00);
        lv(smps_pkg::MODE_RUN, 8'h00, 1'h0, 1'h0);
        pulse(0);
        chk("illegal", ill, 1'h1);
        chk("mode", mode, smps_pkg::MODE_RUN);
        $display("test reset done");
        // stop2 entry, ignored wakes, wake and acknowledge
        wr(4'h0, 8'h13);
        pulse(0);
        lv(smps_pkg::MODE_STOP2, 8'h13, 1'h0, 1'h1);
        chk("osc", osc, 1'h0);
        wr(4'h0, 8'h0F);
        pulse(1);
        pulse(2);
        chk("mode", mode, smps_pkg::MODE_STOP2);
        dbg(smps_pkg::CMD_BACKGROUND);
        chk("dbg", {ack, err, rej, mgo}, 4'h2);
        pulse(3);
        chk("sysreset", srst, 1'h1);
        lv(smps_pkg::MODE_RUN, 8'h00, 1'h0, 1'h1);
        rd(4'h0, 8'h00);
        rd(4'h2, 8'h18);
        wr(4'h3, 8'h00);
        rd(4'h2, 8'h18);
        wr(4'h3, 8'h01);
        rd(4'h2, 8'h00);
        lv(smps_pkg::MODE_RUN, 8'h00, 1'h0, 1'h0);
        $display("test stop2 done");
        // stop3 with low-voltage case first, then random oscillator, adc and regulator settings
        for (int i = 0; i < 5; i++) begin
            c = (i == 0) ? 8'h0F : {2'h0, 4'($urandom), 2'h1};
            wr(4'h0, c);
            pulse(0);
            lv(smps_pkg::MODE_STOP3, c, 1'h0, 1'h0);
            chk("osc", osc, c[4]);
            pulse(1 + i % 2);
            lv(smps_pkg::MODE_RUN, c, 1'h0, 1'h0);
            rd(4'h0, c);
        end
        $display("test stop3 done");
        // debug entry enabled: stop2 request demoted, commands in stop and background
        wr(4'h1, 8'h80);
        rd(4'h1, 8'h80);
        dbg(smps_pkg::CMD_MEM);
        chk("dbg", {ack, err, rej, mgo}, 4'h9);
        wr(4'h0, 8'h03);
        pulse(0);
        lv(smps_pkg::MODE_STOP3, 8'h03, 1'h1, 1'h0);
        dbg(smps_pkg::CMD_MEM_STATUS);
        chk("dbg", {ack, err, rej, mgo}, 4'hC);
        dbg(smps_pkg::CMD_CPU_REG);
        chk("dbg", {ack, err, rej, mgo}, 4'h2);
        dbg(smps_pkg::CMD_BACKGROUND);
        chk("dbg", {ack, err, rej, mgo}, 4'h8);
        chk("mode", mode, smps_pkg::MODE_BACKGROUND);
        rd(4'h1, 8'hC0);
        for (int k = 0; k < 5; k++) begin
            dbg(3'(k));
            chk("dbg", {ack, rej}, 2'h2);
        end
        dbg(smps_pkg::CMD_GO);
        chk("mode", mode, smps_pkg::MODE_RUN);
        wr(4'h1, 8'h00);
        dbg(smps_pkg::CMD_BACKGROUND);
        chk("dbg", {ack, rej}, 2'h1);
        chk("mode", mode, smps_pkg::MODE_RUN);
        $display("test debug done");
        @(posedge clk_sys_in);
        if (exp_q.size() != 0) chk("read queue", 10'h1, 10'h0);
        close_out();
    end
endmodule
`default_nettype wire

// file: logic/smps_pkg.sv
`default_nettype none
package smps_pkg;
    // register bus geometry
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    // register offsets
    localparam logic [3:0] REG_POWER_MODE_CTRL = 4'h0;
    localparam logic [3:0] REG_DEBUG_STATUS_CTRL = 4'h1;
    localparam logic [3:0] REG_STATUS = 4'h2;
    localparam logic [3:0] REG_ACK = 4'h3;
    // power_mode_control_reg fields
    localparam int CTL_STOP_INSTR_ENABLE = 0;
    localparam int CTL_PARTIAL_POWERDOWN_SELECT = 1;
    localparam int CTL_LOWVOLT_DETECT_ENABLE = 2;
    localparam int CTL_LOWVOLT_STOP_ENABLE = 3;
    localparam int CTL_OSC_KEEP_RUNNING = 4;
    localparam int CTL_ADC_ASYNC_CLOCK = 5;
    localparam logic [5:0] CTL_RESET = 6'h00;
    localparam int CTL_W = 6;
    // debug_status_control_reg fields
    localparam int DBG_ENTRY_ENABLE_BIT = 7;
    localparam int DBG_ACTIVE_BIT = 6;
    // status fields
    localparam int STAT_MODE_LSB = 0;
    localparam int STAT_FLAG_BIT = 3;
    localparam int STAT_LATCH_BIT = 4;
    // acknowledge field
    localparam int ACK_RELEASE_BIT = 0;
    // stop mode codes as reported
    localparam logic [1:0] MODE_RUN = 2'h0;
    localparam logic [1:0] MODE_STOP3 = 2'h1;
    localparam logic [1:0] MODE_STOP2 = 2'h2;
    localparam logic [1:0] MODE_BACKGROUND = 2'h3;
    // debug command codes
    localparam logic [2:0] CMD_MEM = 3'h0;
    localparam logic [2:0] CMD_MEM_STATUS = 3'h1;
    localparam logic [2:0] CMD_BACKGROUND = 3'h2;
    localparam logic [2:0] CMD_CPU_REG = 3'h3;
    localparam logic [2:0] CMD_TRACE = 3'h4;
    localparam logic [2:0] CMD_GO = 3'h5;
    // sequencer states
    typedef enum logic [1:0] {
        SMPS_RUN,
        SMPS_STOP3,
        SMPS_STOP2,
        SMPS_BACKGROUND
    } smps_state_t;
endpackage
`default_nettype wire

// file: logic/smps_top.sv
// Functional notes
// - from run, background command enters debug mode only with debug entry enabled
// - debug enabled at STOP keeps debug logic clocks running in stop
// - debug enabled at STOP keeps regulator at full regulation
// - stop2 request with debug entry enabled becomes stop3
// - in stop, memory-with-status commands do no access and report stop error
// - background command in stop wakes to debug mode; then all commands accepted
// - debug-enabled stop3: clock generator and regulator active, core in standby
// - low-voltage detect plus stop enable keep regulator active in stop
// - stop2 request with low-voltage detection in stop becomes stop3
// - low-voltage stop3: clock generator off, regulator on, pins held
// - any stop gates peripheral clocks, even with debug clocks alive
// - pins unchanged entering stop3; latched before entering stop2
// - stop3 keeps all registers and memory contents
// - stop2 wake resets registers, keeps memory, pins latched until acknowledge
// - stop3 clock generator standby unless debug enabled; oscillator runs only with keep-running bit or debug enabled
// - stop2 stops clock generator and oscillator; generator reset on wake
// - ADC standby in stop2, and in stop3 unless async clock; ADC reset after stop2
// - keypad wake works in stop3; keypad disabled in stop2
// - timers and serial units halt in stop, reset after stop2
// - regulator standby in stop unless low-voltage stop or debug enabled
// - STOP enters stop2 with select bit 1, stop3 with 0
// - STOP with stop disabled forces illegal opcode reset, no stop
// - stop2 wake sets power-down flag until acknowledge written with 1
`timescale 1ns/1ps
`default_nettype none
module smps_top (
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic [smps_pkg::ADDR_W-1:0] addr_in,
    input wire logic [smps_pkg::DATA_W-1:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [smps_pkg::DATA_W-1:0] rdata_out,
    input wire logic stop_instr_in,
    input wire logic wake_irq_in,
    input wire logic keypad_wake_in,
    input wire logic stop2_wake_in,
    input wire logic dbg_cmd_valid_in,
    input wire logic [2:0] dbg_cmd_in,
    output logic dbg_ack_out,
    output logic dbg_err_out,
    output logic dbg_rej_out,
    output logic dbg_mem_go_out,
    output logic illegal_reset_out,
    output logic sys_reset_out,
    output logic [1:0] stop_mode_out,
    output logic cpu_clk_en_out,
    output logic periph_clk_en_out,
    output logic debug_clk_en_out,
    output logic regulator_full_out,
    output logic clkgen_active_out,
    output logic osc_run_out,
    output logic adc_standby_out,
    output logic keypad_enable_out,
    output logic pin_latch_out
);
    smps_pkg::smps_state_t state;
    smps_pkg::smps_state_t next_state;
    logic [smps_pkg::CTL_W-1:0] ctrl;
    logic dbg_en;
    logic flag;
    logic pin_latch;
    logic dbg_in_stop;
    logic lowvolt_in_stop;
    logic stop_en;
    logic lowvolt_for_stop;
    logic stop_go;
    logic stop2_exit;
    logic ack_wr;
    logic in_stop;
    logic bg_cmd;
    logic go_cmd;

    // decoded controls
    assign stop_en = ctrl[smps_pkg::CTL_STOP_INSTR_ENABLE];
    assign lowvolt_for_stop = ctrl[smps_pkg::CTL_LOWVOLT_DETECT_ENABLE] & ctrl[smps_pkg::CTL_LOWVOLT_STOP_ENABLE];
    assign stop_go = (state == smps_pkg::SMPS_RUN) && stop_instr_in && stop_en;
    assign stop2_exit = (state == smps_pkg::SMPS_STOP2) && stop2_wake_in;
    assign ack_wr = wr_in && (addr_in == smps_pkg::REG_ACK) && wdata_in[smps_pkg::ACK_RELEASE_BIT];
    assign in_stop = (state == smps_pkg::SMPS_STOP3) || (state == smps_pkg::SMPS_STOP2);
    assign bg_cmd = dbg_cmd_valid_in && (dbg_cmd_in == smps_pkg::CMD_BACKGROUND);
    assign go_cmd = dbg_cmd_valid_in && (dbg_cmd_in == smps_pkg::CMD_GO);

    // mode decision and wake paths
    always_comb begin
        next_state = state;
        unique case (state)
            smps_pkg::SMPS_RUN: begin
                if (stop_go) begin
                    if (ctrl[smps_pkg::CTL_PARTIAL_POWERDOWN_SELECT] && !dbg_en
                        && !lowvolt_for_stop) begin
                        next_state = smps_pkg::SMPS_STOP2;
                    end else begin
                        next_state = smps_pkg::SMPS_STOP3;
                    end
                end else if (bg_cmd && dbg_en) begin
                    next_state = smps_pkg::SMPS_BACKGROUND;
                end
            end
            smps_pkg::SMPS_STOP3: begin
                if (bg_cmd && dbg_in_stop) begin
                    next_state = smps_pkg::SMPS_BACKGROUND;
                end else if (wake_irq_in || keypad_wake_in) begin
                    next_state = smps_pkg::SMPS_RUN;
                end
            end
            smps_pkg::SMPS_STOP2: begin
                if (stop2_wake_in) begin
                    next_state = smps_pkg::SMPS_RUN;
                end
            end
            smps_pkg::SMPS_BACKGROUND: begin
                if (go_cmd) begin
                    next_state = smps_pkg::SMPS_RUN;
                end
            end
        endcase
    end

    // state register
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            state <= smps_pkg::SMPS_RUN;
        end else begin
            state <= next_state;
        end
    end

    // stop-entry snapshot of debug and low-voltage settings
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            dbg_in_stop <= 1'b0;
            lowvolt_in_stop <= 1'b0;
        end else if (stop_go) begin
            dbg_in_stop <= dbg_en;
            lowvolt_in_stop <= lowvolt_for_stop;
        end
    end

    // control registers; held through stop3, cleared on stop2 wake
    always_ff @(posedge clk_sys_in) begin
        if (rst_in || stop2_exit) begin
            ctrl <= smps_pkg::CTL_RESET;
            dbg_en <= 1'b0;
        end else if (wr_in && addr_in == smps_pkg::REG_POWER_MODE_CTRL) begin
            ctrl <= wdata_in[smps_pkg::CTL_W-1:0];
        end else if (wr_in && addr_in == smps_pkg::REG_DEBUG_STATUS_CTRL) begin
            dbg_en <= wdata_in[smps_pkg::DBG_ENTRY_ENABLE_BIT];
        end
    end

    // power-down flag: wake sets it, acknowledge clears; set wins
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            flag <= 1'b0;
        end else if (stop2_exit) begin
            flag <= 1'b1;
        end else if (ack_wr) begin
            flag <= 1'b0;
        end
    end

    // pin latches close before stop2 and open on acknowledge
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            pin_latch <= 1'b0;
        end else if (next_state == smps_pkg::SMPS_STOP2 && state != smps_pkg::SMPS_STOP2) begin
            pin_latch <= 1'b1;
        end else if (ack_wr && !stop2_exit && state != smps_pkg::SMPS_STOP2) begin
            pin_latch <= 1'b0;
        end
    end

    // reset pulses: illegal stop and stop2 wake
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            illegal_reset_out <= 1'b0;
            sys_reset_out <= 1'b0;
        end else begin
            illegal_reset_out <= (state == smps_pkg::SMPS_RUN) && stop_instr_in && !stop_en;
            sys_reset_out <= stop2_exit;
        end
    end

    // debug command answers, one cycle after the command
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            dbg_ack_out <= 1'b0;
            dbg_err_out <= 1'b0;
            dbg_rej_out <= 1'b0;
            dbg_mem_go_out <= 1'b0;
        end else begin
            dbg_ack_out <= 1'b0;
            dbg_err_out <= 1'b0;
            dbg_rej_out <= 1'b0;
            dbg_mem_go_out <= 1'b0;
            if (dbg_cmd_valid_in) begin
                unique case (state)
                    smps_pkg::SMPS_RUN: begin
                        if (dbg_cmd_in == smps_pkg::CMD_MEM || dbg_cmd_in == smps_pkg::CMD_MEM_STATUS) begin
                            dbg_ack_out <= 1'b1;
                            dbg_mem_go_out <= 1'b1;
                        end else if (dbg_cmd_in == smps_pkg::CMD_BACKGROUND && dbg_en) begin
                            dbg_ack_out <= 1'b1;
                        end else begin
                            dbg_rej_out <= 1'b1;
                        end
                    end
                    smps_pkg::SMPS_STOP3: begin
                        if (dbg_in_stop && dbg_cmd_in == smps_pkg::CMD_MEM_STATUS) begin
                            dbg_ack_out <= 1'b1;
                            dbg_err_out <= 1'b1;
                        end else if (dbg_in_stop && dbg_cmd_in == smps_pkg::CMD_BACKGROUND) begin
                            dbg_ack_out <= 1'b1;
                        end else begin
                            dbg_rej_out <= 1'b1;
                        end
                    end
                    smps_pkg::SMPS_STOP2: begin
                        dbg_rej_out <= 1'b1;
                    end
                    smps_pkg::SMPS_BACKGROUND: begin
                        dbg_ack_out <= 1'b1;
                        dbg_mem_go_out <= (dbg_cmd_in == smps_pkg::CMD_MEM)
                            || (dbg_cmd_in == smps_pkg::CMD_MEM_STATUS);
                    end
                endcase
            end
        end
    end

    // register read port, data one cycle after the strobe
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            rdata_out <= 8'h00;
        end else if (rd_in) begin
            unique case (addr_in)
                smps_pkg::REG_POWER_MODE_CTRL: rdata_out <= {2'h0, ctrl};
                smps_pkg::REG_DEBUG_STATUS_CTRL: rdata_out <= {dbg_en, state == smps_pkg::SMPS_BACKGROUND, 6'h00};
                smps_pkg::REG_STATUS: rdata_out <= {3'h0, pin_latch, flag, 1'b0, stop_mode_out};
                default: rdata_out <= 8'h00;
            endcase
        end else begin
            rdata_out <= 8'h00;
        end
    end

    // mode report
    always_comb begin
        unique case (state)
            smps_pkg::SMPS_RUN: stop_mode_out = smps_pkg::MODE_RUN;
            smps_pkg::SMPS_STOP3: stop_mode_out = smps_pkg::MODE_STOP3;
            smps_pkg::SMPS_STOP2: stop_mode_out = smps_pkg::MODE_STOP2;
            smps_pkg::SMPS_BACKGROUND: stop_mode_out = smps_pkg::MODE_BACKGROUND;
        endcase
    end

    // power and clock controls decoded from the state flops
    assign cpu_clk_en_out = (state == smps_pkg::SMPS_RUN) || (state == smps_pkg::SMPS_BACKGROUND);
    assign periph_clk_en_out = !in_stop;
    assign debug_clk_en_out = !in_stop || (state == smps_pkg::SMPS_STOP3 && dbg_in_stop);
    assign regulator_full_out = !in_stop || dbg_in_stop || lowvolt_in_stop;
    assign clkgen_active_out = !in_stop || (state == smps_pkg::SMPS_STOP3 && dbg_in_stop);
    assign osc_run_out = clkgen_active_out
        || (state == smps_pkg::SMPS_STOP3 && ctrl[smps_pkg::CTL_OSC_KEEP_RUNNING]);
    assign adc_standby_out = (state == smps_pkg::SMPS_STOP2)
        || (state == smps_pkg::SMPS_STOP3 && !ctrl[smps_pkg::CTL_ADC_ASYNC_CLOCK]);
    assign keypad_enable_out = state != smps_pkg::SMPS_STOP2;
    assign pin_latch_out = pin_latch;

    // stop decision checks
    stop2_entry_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        stop_go && ctrl[smps_pkg::CTL_PARTIAL_POWERDOWN_SELECT] && !dbg_en && !lowvolt_for_stop
        |=> state == smps_pkg::SMPS_STOP2 && pin_latch_out)
        else $error("stop2 not entered");
    stop3_select_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        stop_go && !ctrl[smps_pkg::CTL_PARTIAL_POWERDOWN_SELECT] |=> state == smps_pkg::SMPS_STOP3)
        else $error("stop3 not entered");
    pins_hold_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        stop_go && !ctrl[smps_pkg::CTL_PARTIAL_POWERDOWN_SELECT] && !ack_wr |=> $stable(pin_latch_out))
        else $error("pin latch changed entering stop3");
    debug_demote_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        stop_go && dbg_en |=> state == smps_pkg::SMPS_STOP3 && debug_clk_en_out && clkgen_active_out)
        else $error("debug stop not demoted to stop3");
    lowvolt_demote_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        stop_go && lowvolt_for_stop |=> state == smps_pkg::SMPS_STOP3 && regulator_full_out)
        else $error("low-voltage stop not demoted to stop3");
    illegal_stop_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        state == smps_pkg::SMPS_RUN && stop_instr_in && !stop_en |=> illegal_reset_out && !in_stop)
        else $error("illegal stop not reset");
    stop_sample_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        stop_go
        |=> dbg_in_stop == $past(dbg_en) && lowvolt_in_stop == $past(lowvolt_for_stop))
        else $error("stop settings not sampled at entry");

    // power and clock checks
    periph_gate_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        stop_go |=> !periph_clk_en_out && !cpu_clk_en_out)
        else $error("peripheral clock running in stop");
    debug_clock_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        stop_go && dbg_en |=> debug_clk_en_out)
        else $error("debug clock stopped in stop");
    regulator_keep_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        stop_go && dbg_en |=> regulator_full_out)
        else $error("regulator in standby with debug enabled");
    clkgen_off_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        stop_go && lowvolt_for_stop && !dbg_en |=> !clkgen_active_out && regulator_full_out)
        else $error("clock generator running in low-voltage stop");
    regulator_stby_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        in_stop && !$past(dbg_en) && !$past(lowvolt_for_stop) && $past(stop_go) |-> !regulator_full_out)
        else $error("regulator not in standby");
    osc_stop2_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        state == smps_pkg::SMPS_STOP2 |-> !osc_run_out && !clkgen_active_out)
        else $error("oscillator running in stop2");
    adc_stop2_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        state == smps_pkg::SMPS_STOP2 |-> adc_standby_out && !keypad_enable_out)
        else $error("adc or keypad active in stop2");

    // wake and debug checks
    status_error_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        state == smps_pkg::SMPS_STOP3 && dbg_in_stop && dbg_cmd_valid_in && dbg_cmd_in == smps_pkg::CMD_MEM_STATUS
        |=> dbg_err_out && !dbg_mem_go_out)
        else $error("status command not refused in stop");
    bg_wake_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        state == smps_pkg::SMPS_STOP3 && dbg_in_stop && bg_cmd
        |=> state == smps_pkg::SMPS_BACKGROUND && dbg_ack_out)
        else $error("background command did not wake");
    debug_entry_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        state == smps_pkg::SMPS_RUN && bg_cmd && !dbg_en && !stop_instr_in |=> state == smps_pkg::SMPS_RUN)
        else $error("debug mode entered while disabled");
    keypad_wake_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        state == smps_pkg::SMPS_STOP3 && keypad_wake_in && !bg_cmd |=> state == smps_pkg::SMPS_RUN)
        else $error("keypad did not wake stop3");
    wake_reset_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        stop2_exit |=> sys_reset_out && ctrl == smps_pkg::CTL_RESET && !dbg_en && pin_latch_out)
        else $error("stop2 wake did not reset");
    flag_hold_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        stop2_exit ##1 (!ack_wr)[*2] |=> flag && pin_latch_out)
        else $error("power-down flag lost before acknowledge");
    ack_release_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        state == smps_pkg::SMPS_RUN && ack_wr && !stop_go |=> !flag && !pin_latch_out)
        else $error("acknowledge did not release");
endmodule
`default_nettype wire
